// ### inc/smsb_map.svh
// register offsets, opcodes, signatures, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and design files
`ifndef SMSB_MAP_SVH
`define SMSB_MAP_SVH

// apb byte offsets
`define SMSB_OFF_FEAT 8'h00
`define SMSB_OFF_SECCNT 8'h04
`define SMSB_OFF_CYL_LO 8'h08
`define SMSB_OFF_CYL_HI 8'h0c
`define SMSB_OFF_CMD 8'h10
`define SMSB_OFF_STATUS 8'h14
`define SMSB_OFF_ERROR 8'h18
`define SMSB_OFF_CFG 8'h1c
`define SMSB_OFF_IRQ_STAT 8'h20
`define SMSB_OFF_IRQ_MASK 8'h24
`define SMSB_OFF_ATTR 8'h28
`define SMSB_OFF_THR 8'h2c
`define SMSB_OFF_PWR 8'h30

// opcodes and subcommand signature
`define SMSB_OP_SMART 8'hb0
`define SMSB_OP_STBY_A 8'h96
`define SMSB_OP_STBY_B 8'he2
`define SMSB_OP_STBYI_A 8'h94
`define SMSB_OP_STBYI_B 8'he0
`define SMSB_FT_STATUS 8'hda
`define SMSB_FT_SAVE 8'hd3
`define SMSB_SIG_LO 8'h4f
`define SMSB_SIG_HI 8'hc2
`define SMSB_BAD_LO 8'hf4
`define SMSB_BAD_HI 8'h2c

// status and error bit positions
`define SMSB_ST_BSY 7
`define SMSB_ST_DRDY 6
`define SMSB_ST_ERR 0
`define SMSB_ER_ABRT 2

// config bits: monitor enable, monitor support, power mgmt support, drive ready
`define SMSB_CFG_SMART_EN 0
`define SMSB_CFG_SMART_SUP 1
`define SMSB_CFG_PM_SUP 2
`define SMSB_CFG_DRDY 3
`define SMSB_CFG_RST 4'he

// interrupt status bits
`define SMSB_IRQ_DONE 0
`define SMSB_IRQ_ABORT 1
`define SMSB_IRQ_TMR 2

// attribute storage
`define SMSB_ATTR_INIT 8'h64
`define SMSB_ATTR_LAST 3'h7

// standby timer unit, clock period and derived cycle count
`define SMSB_CLK_NS 5
`define SMSB_TICK_NS 5000
`define SMSB_TICK_CYC ((`SMSB_TICK_NS + `SMSB_CLK_NS - 1) / `SMSB_CLK_NS)

`endif

// ### inc/smsb_pkg.sv
// types and opcode classifiers for the monitor and standby command block
// assumes smsb_map.svh on the include path
`include "smsb_map.svh"

package smsb_pkg;

	typedef enum logic [2:0] {
		SMSB_IDLE = 3'h0,
		SMSB_DEC = 3'h1,
		SMSB_SAVE = 3'h3,
		SMSB_CMP = 3'h2,
		SMSB_FIN = 3'h6
	} smsb_state_t;

	typedef enum logic [1:0] {
		SMSB_K_NONE = 2'h0,
		SMSB_K_STATUS = 2'h1,
		SMSB_K_SAVE = 2'h2,
		SMSB_K_STBY = 2'h3
	} smsb_kind_t;

	function automatic logic smsb_is_stby(input logic [7:0] op);
		return (op == `SMSB_OP_STBY_A) || (op == `SMSB_OP_STBY_B);
	endfunction : smsb_is_stby

	function automatic logic smsb_is_stbyi(input logic [7:0] op);
		return (op == `SMSB_OP_STBYI_A) || (op == `SMSB_OP_STBYI_B);
	endfunction : smsb_is_stbyi

endpackage : smsb_pkg

// ### design/smsb_attr_store.sv
// attribute working values, thresholds and non-volatile copy with a save walker
// assumes single clock pclk; save_req is a one-cycle pulse from the command logic
`timescale 1ns/100ps
`default_nettype none
`include "smsb_map.svh"

module smsb_attr_store (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// software updates
	input wire logic val_we,
	input wire logic thr_we,
	input wire logic [2:0] idx,
	input wire logic [7:0] data,
	// save and compare
	input wire logic save_req,
	output logic save_busy,
	output logic exceeded
);

	logic [7:0] work [8];
	logic [7:0] nv [8];
	logic [7:0] thr [8];
	logic [7:0] dirty;
	logic [2:0] ptr;
	logic [7:0] next_work [8];
	logic [7:0] next_nv [8];
	logic [7:0] next_thr [8];
	logic [7:0] next_dirty;
	logic [2:0] next_ptr;
	logic next_busy;
	logic [7:0] cur_work;

	assign cur_work = work[ptr];

	always_comb begin
		next_work = work;
		next_nv = nv;
		next_thr = thr;
		next_dirty = dirty;
		next_ptr = ptr;
		next_busy = save_busy;
		// one entry per cycle, whole table walked on every save
		if (save_busy) begin
			if (dirty[ptr]) begin
				next_nv[ptr] = work[ptr];
				next_dirty[ptr] = 1'b0;
			end
			next_ptr = 3'(ptr + 3'h1);
			if (ptr == `SMSB_ATTR_LAST) begin
				next_busy = 1'b0;
			end
		end else if (save_req) begin
			next_busy = 1'b1;
			next_ptr = 3'h0;
		end
		// a late update stays dirty for the next save
		if (val_we) begin
			next_work[idx] = data;
			next_dirty[idx] = 1'b1;
		end
		if (thr_we) begin
			next_thr[idx] = data;
		end
	end

	always_comb begin
		exceeded = 1'b0;
		for (int i = 0; i < 8; i++) begin
			// zero threshold marks an unused entry
			if (thr[i] != 8'h00 && nv[i] <= thr[i]) begin
				exceeded = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				work[i] <= `SMSB_ATTR_INIT;
				nv[i] <= `SMSB_ATTR_INIT;
				thr[i] <= 8'h00;
			end
			dirty <= 8'h00;
			ptr <= 3'h0;
			save_busy <= 1'b0;
		end else begin
			work <= next_work;
			nv <= next_nv;
			thr <= next_thr;
			dirty <= next_dirty;
			ptr <= next_ptr;
			save_busy <= next_busy;
		end
	end

	AST_SAVE_WALK: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(save_busy) |-> save_busy [*8] ##1 !save_busy)
		else $error("save walk length wrong");

	AST_SAVE_COMMIT: assert property (@(posedge pclk) disable iff (!presetn)
		save_busy && dirty[ptr] |=> nv[$past(ptr)] == $past(cur_work))
		else $error("dirty attribute not committed");

endmodule : smsb_attr_store
`default_nettype wire

// ### design/smsb_stby_timer.sv
// standby timer: period in units of a prescaled tick, restarted by command activity
// assumes load and restart are one-cycle pulses on pclk
`timescale 1ns/100ps
`default_nettype none
`include "smsb_map.svh"

module smsb_stby_timer #(
	parameter int TICK_CYCLES = `SMSB_TICK_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// programming
	input wire logic load,
	input wire logic [7:0] period,
	input wire logic restart,
	// state and expiry
	output logic enabled,
	output logic [7:0] period_q,
	output logic expire
);

	logic [31:0] pre;
	logic [7:0] cnt;
	logic [31:0] next_pre;
	logic [7:0] next_cnt;
	logic [7:0] next_per;
	logic next_en;
	logic next_exp;

	always_comb begin
		next_pre = pre;
		next_cnt = cnt;
		next_per = period_q;
		next_en = enabled;
		next_exp = 1'b0;
		if (load) begin
			next_en = (period != 8'h00);
			next_per = period;
			next_cnt = period;
			next_pre = 32'h0;
		end else if (restart && enabled) begin
			next_cnt = period_q;
			next_pre = 32'h0;
		end else if (enabled && cnt != 8'h00) begin
			// stops at zero until command activity restarts it
			if (pre == 32'(TICK_CYCLES - 1)) begin
				next_pre = 32'h0;
				next_cnt = 8'(cnt - 8'h01);
				next_exp = (cnt == 8'h01);
			end else begin
				next_pre = 32'(pre + 32'h1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre <= 32'h0;
			cnt <= 8'h00;
			period_q <= 8'h00;
			enabled <= 1'b0;
			expire <= 1'b0;
		end else begin
			pre <= next_pre;
			cnt <= next_cnt;
			period_q <= next_per;
			enabled <= next_en;
			expire <= next_exp;
		end
	end

	AST_TMR_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
		load && period != 8'h00 |=> enabled && period_q == $past(period))
		else $error("timer not enabled with period");

	AST_TMR_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)
		load && period == 8'h00 |=> !enabled ##1 !expire)
		else $error("timer not disabled by zero count");

endmodule : smsb_stby_timer
`default_nettype wire

// ### design/smsb_cmd.sv
// monitor and standby command interpreter with apb register file and interrupt
// assumes a single clock pclk; the host side is an apb master on the same clock
//
// Overview of operation
// - a status request with no threshold exceeded leaves cylinder low 4Fh and cylinder high C2h.
// - a status request with a threshold exceeded writes F4h to cylinder low and 2Ch to cylinder high.
// - a status request raises busy, commits updated attributes, then compares them to thresholds.
// - either monitor subcommand aborts when unsupported, disabled or given a bad signature.
// - a save request writes updated attributes at once, whatever the autosave timer holds.
// - a save runs busy, store, busy low, then interrupt, in that order.
// - opcodes 96h and E2h are standby with timer, the period taken from the sector count.
// - a non-zero sector count enables the standby timer with that period.
// - a zero sector count disables the standby timer.
// - standby sets busy, enters standby, clears busy and interrupts, possibly before the transition ends.
// - opcodes 94h and E0h are standby immediate with the same sequence and no operand.
// - without power management support both standby opcodes abort and power state is unchanged.
// - none of these commands has a data phase; completion is status bits and the interrupt.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "smsb_map.svh"

module smsb_cmd #(
	parameter int TICK_CYCLES = `SMSB_TICK_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device state
	output logic intrq,
	output logic dev_busy,
	output logic standby_mode
);

	smsb_pkg::smsb_state_t state;
	smsb_pkg::smsb_state_t next_state;
	smsb_pkg::smsb_kind_t kind;
	smsb_pkg::smsb_kind_t next_kind;
	logic [7:0] opc;
	logic [7:0] feat;
	logic [7:0] seccnt;
	logic [7:0] cyl_lo;
	logic [7:0] cyl_hi;
	logic err;
	logic abrt;
	logic [3:0] cfg;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [7:0] next_opc;
	logic [7:0] next_feat;
	logic [7:0] next_seccnt;
	logic [7:0] next_cyl_lo;
	logic [7:0] next_cyl_hi;
	logic next_bsy;
	logic next_err;
	logic next_abrt;
	logic [3:0] next_cfg;
	logic [2:0] next_irq_stat;
	logic [2:0] next_irq_mask;
	logic next_standby;
	logic [2:0] ev;
	logic wr_acc;
	logic rd_acc;
	logic cmd_acc;
	logic is_smart;
	logic is_stby;
	logic is_stbyi;
	logic smart_bad;
	logic abort_now;
	logic save_req;
	logic save_busy;
	logic exceeded;
	logic tmr_load;
	logic tmr_en;
	logic tmr_exp;
	logic [7:0] tmr_per;
	logic [31:0] next_prdata;
	logic bad_q;
	logic next_bad;

	assign pready = 1'b1;
	assign pslverr = psel && penable && bad_q;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign cmd_acc = wr_acc && paddr == `SMSB_OFF_CMD && !dev_busy;
	assign intrq = |(irq_stat & irq_mask);

	// opcode and signature decode
	assign is_smart = (opc == `SMSB_OP_SMART);
	assign is_stby = smsb_pkg::smsb_is_stby(opc);
	assign is_stbyi = smsb_pkg::smsb_is_stbyi(opc);
	assign smart_bad = !cfg[`SMSB_CFG_SMART_SUP] || !cfg[`SMSB_CFG_SMART_EN]
		|| cyl_lo != `SMSB_SIG_LO || cyl_hi != `SMSB_SIG_HI
		|| (feat != `SMSB_FT_STATUS && feat != `SMSB_FT_SAVE);
	// unknown opcodes abort as well
	assign abort_now = is_smart ? smart_bad
		: (is_stby || is_stbyi) ? !cfg[`SMSB_CFG_PM_SUP] : 1'b1;
	assign save_req = (state == smsb_pkg::SMSB_DEC) && is_smart && !abort_now;
	assign tmr_load = (state == smsb_pkg::SMSB_DEC) && is_stby && !abort_now;

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_opc = opc;
		next_feat = feat;
		next_seccnt = seccnt;
		next_cyl_lo = cyl_lo;
		next_cyl_hi = cyl_hi;
		next_bsy = dev_busy;
		next_err = err;
		next_abrt = abrt;
		next_cfg = cfg;
		next_irq_mask = irq_mask;
		next_standby = standby_mode;
		ev = 3'h0;
		// host writes; command block is frozen while busy
		if (wr_acc) begin
			case (paddr)
				`SMSB_OFF_FEAT: begin
					if (!dev_busy) next_feat = pwdata[7:0];
				end
				`SMSB_OFF_SECCNT: begin
					if (!dev_busy) next_seccnt = pwdata[7:0];
				end
				`SMSB_OFF_CYL_LO: begin
					if (!dev_busy) next_cyl_lo = pwdata[7:0];
				end
				`SMSB_OFF_CYL_HI: begin
					if (!dev_busy) next_cyl_hi = pwdata[7:0];
				end
				`SMSB_OFF_CMD: begin
					if (!dev_busy) begin
						next_opc = pwdata[7:0];
						next_bsy = 1'b1;
						next_err = 1'b0;
						next_abrt = 1'b0;
						next_state = smsb_pkg::SMSB_DEC;
					end
				end
				`SMSB_OFF_CFG: next_cfg = pwdata[3:0];
				`SMSB_OFF_IRQ_MASK: next_irq_mask = pwdata[2:0];
				`SMSB_OFF_PWR: begin
					if (!pwdata[0]) next_standby = 1'b0;
				end
				default: ;
			endcase
		end
		// no data phase: every command ends in status bits and the interrupt
		case (state)
			smsb_pkg::SMSB_DEC: begin
				if (abort_now) begin
					next_err = 1'b1;
					next_abrt = 1'b1;
					next_bsy = 1'b0;
					next_state = smsb_pkg::SMSB_FIN;
				end else if (is_smart) begin
					next_kind = (feat == `SMSB_FT_STATUS) ? smsb_pkg::SMSB_K_STATUS : smsb_pkg::SMSB_K_SAVE;
					next_state = smsb_pkg::SMSB_SAVE;
				end else begin
					// done is signalled while the power transition may still run
					next_standby = 1'b1;
					next_kind = smsb_pkg::SMSB_K_STBY;
					next_bsy = 1'b0;
					next_state = smsb_pkg::SMSB_FIN;
				end
			end
			smsb_pkg::SMSB_SAVE: begin
				if (!save_busy) begin
					if (kind == smsb_pkg::SMSB_K_STATUS) begin
						next_state = smsb_pkg::SMSB_CMP;
					end else begin
						next_bsy = 1'b0;
						next_state = smsb_pkg::SMSB_FIN;
					end
				end
			end
			smsb_pkg::SMSB_CMP: begin
				next_cyl_lo = exceeded ? `SMSB_BAD_LO : `SMSB_SIG_LO;
				next_cyl_hi = exceeded ? `SMSB_BAD_HI : `SMSB_SIG_HI;
				next_bsy = 1'b0;
				next_state = smsb_pkg::SMSB_FIN;
			end
			smsb_pkg::SMSB_FIN: begin
				ev[`SMSB_IRQ_DONE] = 1'b1;
				ev[`SMSB_IRQ_ABORT] = err;
				next_kind = smsb_pkg::SMSB_K_NONE;
				if (!cmd_acc) next_state = smsb_pkg::SMSB_IDLE;
			end
			smsb_pkg::SMSB_IDLE: ;
			default: next_state = smsb_pkg::SMSB_IDLE;
		endcase
		// timer expiry beats a wake write in the same cycle
		if (tmr_exp) begin
			next_standby = 1'b1;
			ev[`SMSB_IRQ_TMR] = 1'b1;
		end
		// read clears, a new event in the same cycle survives
		next_irq_stat = irq_stat;
		if (rd_acc && paddr == `SMSB_OFF_IRQ_STAT) next_irq_stat = 3'h0;
		next_irq_stat = next_irq_stat | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= smsb_pkg::SMSB_IDLE;
			kind <= smsb_pkg::SMSB_K_NONE;
			opc <= 8'h00;
			feat <= 8'h00;
			seccnt <= 8'h00;
			cyl_lo <= 8'h00;
			cyl_hi <= 8'h00;
			dev_busy <= 1'b0;
			err <= 1'b0;
			abrt <= 1'b0;
			cfg <= `SMSB_CFG_RST;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			standby_mode <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			opc <= next_opc;
			feat <= next_feat;
			seccnt <= next_seccnt;
			cyl_lo <= next_cyl_lo;
			cyl_hi <= next_cyl_hi;
			dev_busy <= next_bsy;
			err <= next_err;
			abrt <= next_abrt;
			cfg <= next_cfg;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			standby_mode <= next_standby;
		end
	end

	// read data is captured in the setup phase, so it comes from flip-flops
	always_comb begin
		next_prdata = prdata;
		next_bad = bad_q;
		if (psel && !penable) begin
			next_prdata = 32'h0;
			next_bad = 1'b0;
			case (paddr)
				`SMSB_OFF_FEAT: next_prdata[7:0] = feat;
				`SMSB_OFF_SECCNT: next_prdata[7:0] = seccnt;
				`SMSB_OFF_CYL_LO: next_prdata[7:0] = cyl_lo;
				`SMSB_OFF_CYL_HI: next_prdata[7:0] = cyl_hi;
				`SMSB_OFF_CMD: next_prdata[7:0] = opc;
				`SMSB_OFF_STATUS: begin
					next_prdata[`SMSB_ST_BSY] = dev_busy;
					next_prdata[`SMSB_ST_DRDY] = cfg[`SMSB_CFG_DRDY];
					next_prdata[`SMSB_ST_ERR] = err;
				end
				`SMSB_OFF_ERROR: next_prdata[`SMSB_ER_ABRT] = abrt;
				`SMSB_OFF_CFG: next_prdata[3:0] = cfg;
				`SMSB_OFF_IRQ_STAT: next_prdata[2:0] = next_irq_stat;
				`SMSB_OFF_IRQ_MASK: next_prdata[2:0] = irq_mask;
				`SMSB_OFF_ATTR: ;
				`SMSB_OFF_THR: ;
				`SMSB_OFF_PWR: next_prdata[15:0] = {tmr_per, 6'h00, tmr_en, standby_mode};
				default: next_bad = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			bad_q <= 1'b0;
		end else begin
			prdata <= next_prdata;
			bad_q <= next_bad;
		end
	end

	smsb_attr_store u_store (
		.pclk(pclk),
		.presetn(presetn),
		.val_we(wr_acc && paddr == `SMSB_OFF_ATTR),
		.thr_we(wr_acc && paddr == `SMSB_OFF_THR),
		.idx(pwdata[2:0]),
		.data(pwdata[15:8]),
		.save_req(save_req),
		.save_busy(save_busy),
		.exceeded(exceeded)
	);

	smsb_stby_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(tmr_load),
		.period(seccnt),
		.restart(cmd_acc),
		.enabled(tmr_en),
		.period_q(tmr_per),
		.expire(tmr_exp)
	);

	AST_BSY_ON_CMD: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_acc |=> dev_busy && state == smsb_pkg::SMSB_DEC)
		else $error("busy not raised on command");

	AST_STATUS_PASS: assert property (@(posedge pclk) disable iff (!presetn)
		state == smsb_pkg::SMSB_CMP && !exceeded |=> cyl_lo == `SMSB_SIG_LO && cyl_hi == `SMSB_SIG_HI)
		else $error("pass signature missing");

	AST_STATUS_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
		state == smsb_pkg::SMSB_CMP && exceeded |=> cyl_lo == `SMSB_BAD_LO && cyl_hi == `SMSB_BAD_HI)
		else $error("fail signature missing");

	AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
		state == smsb_pkg::SMSB_DEC && abort_now |=> err && abrt && !dev_busy ##1 irq_stat[`SMSB_IRQ_ABORT])
		else $error("abort not posted");

	AST_SAVE_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		save_req |=> save_busy && dev_busy && state == smsb_pkg::SMSB_SAVE)
		else $error("save not started at once");

	// a command taken in the done cycle may raise busy again as the bit lands
	AST_IRQ_AFTER_BSY: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(irq_stat[`SMSB_IRQ_DONE]) |-> $past(state) == smsb_pkg::SMSB_FIN && $past(dev_busy) == 1'b0)
		else $error("interrupt before busy low");

	AST_STATUS_DONE: assert property (@(posedge pclk) disable iff (!presetn)
		state == smsb_pkg::SMSB_CMP |=> !dev_busy && state == smsb_pkg::SMSB_FIN ##1 irq_stat[`SMSB_IRQ_DONE])
		else $error("status completion wrong");

	AST_STBY_ENTER: assert property (@(posedge pclk) disable iff (!presetn)
		state == smsb_pkg::SMSB_DEC && !abort_now && !is_smart |=> standby_mode && !dev_busy)
		else $error("standby not entered");

	AST_STBY_NOPM: assert property (@(posedge pclk) disable iff (!presetn)
		state == smsb_pkg::SMSB_DEC && (is_stby || is_stbyi) && !cfg[`SMSB_CFG_PM_SUP] && !tmr_exp
		|=> standby_mode == $past(standby_mode) && abrt)
		else $error("power state changed without support");

endmodule : smsb_cmd
`default_nettype wire

// ### verification/smsb_host.sv
// apb host model: single register transfers and command issue
// assumes pclk from the bench; each transfer starts one edge after the call
`timescale 1ns/100ps
`default_nettype none
`include "smsb_map.svh"

module smsb_host (
	// clock
	input wire logic pclk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int hangs = 0;
	logic err = 1'b0;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16)
			hangs++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines flip so a stale value cannot pass
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer

	// operands first, opcode last, no data phase
	task automatic issue(input logic [7:0] ft, sc, cl, ch, op);
		logic [31:0] q;
		xfer(1'b1, `SMSB_OFF_FEAT, {24'h0, ft}, q);
		xfer(1'b1, `SMSB_OFF_SECCNT, {24'h0, sc}, q);
		xfer(1'b1, `SMSB_OFF_CYL_LO, {24'h0, cl}, q);
		xfer(1'b1, `SMSB_OFF_CYL_HI, {24'h0, ch}, q);
		xfer(1'b1, `SMSB_OFF_CMD, {24'h0, op}, q);
	endtask : issue
endmodule : smsb_host
`default_nettype wire

// ### verification/smart_status_standby_cmd_tb.sv
// self-checking bench for the monitor and standby command block
// assumes smsb_host drives the apb side; timer tick shortened to 4 cycles
`timescale 1ns/100ps
`default_nettype none
`include "smsb_map.svh"

module smart_status_standby_cmd_tb;
	typedef struct packed {
		logic [3:0] cfg;
		logic [7:0] ft, sc, cl, ch, op;
		logic err, stby, tmr, bad;
	} smsb_row_t;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, intrq, dev_busy, standby_mode;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int fail_count = 0;
	int checks = 0;
	smsb_row_t xrow = '{4'hf, 8'hda, 8'h00, 8'h4f, 8'hc2, 8'hb0, 1'b0, 1'b0, 1'b0, 1'b1};
	smsb_row_t rows [14] = '{
		'{4'he, 8'hda, 8'h00, 8'h4f, 8'hc2, 8'hb0, 1'b1, 1'b0, 1'b0, 1'b0},
		'{4'hf, 8'hda, 8'h00, 8'h4f, 8'hc2, 8'hb0, 1'b0, 1'b0, 1'b0, 1'b0},
		'{4'hf, 8'hd3, 8'h00, 8'h4f, 8'hc2, 8'hb0, 1'b0, 1'b0, 1'b0, 1'b0},
		'{4'hf, 8'hda, 8'h00, 8'h4e, 8'hc2, 8'hb0, 1'b1, 1'b0, 1'b0, 1'b0},
		'{4'hf, 8'hda, 8'h00, 8'h4f, 8'hc3, 8'hb0, 1'b1, 1'b0, 1'b0, 1'b0},
		'{4'hf, 8'h12, 8'h00, 8'h4f, 8'hc2, 8'hb0, 1'b1, 1'b0, 1'b0, 1'b0},
		'{4'hd, 8'hda, 8'h00, 8'h4f, 8'hc2, 8'hb0, 1'b1, 1'b0, 1'b0, 1'b0},
		'{4'hf, 8'h00, 8'hc8, 8'h00, 8'h00, 8'h96, 1'b0, 1'b1, 1'b1, 1'b0},
		'{4'hf, 8'h00, 8'h00, 8'h00, 8'h00, 8'he2, 1'b0, 1'b1, 1'b0, 1'b0},
		'{4'hf, 8'h00, 8'h05, 8'h00, 8'h00, 8'h94, 1'b0, 1'b1, 1'b0, 1'b0},
		'{4'hf, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 1'b0, 1'b1, 1'b0, 1'b0},
		'{4'hb, 8'h00, 8'hc8, 8'h00, 8'h00, 8'h96, 1'b1, 1'b0, 1'b0, 1'b0},
		'{4'hb, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 1'b1, 1'b0, 1'b0, 1'b0},
		'{4'hf, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 1'b1, 1'b0, 1'b0, 1'b0}
	};

	always #2.5 pclk = ~pclk;

	smsb_cmd #(.TICK_CYCLES(4)) u_smsb_cmd (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.intrq(intrq), .dev_busy(dev_busy), .standby_mode(standby_mode));

	smsb_host u_smsb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic end_sim();
		fail_count += u_smsb_host.hangs;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tmo(input logic ok);
		if (ok !== 1'b1) begin
			fail_count++;
			end_sim();
		end
	endtask : tmo

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_smsb_host.xfer(1'b1, a, d, q);
		tmo(u_smsb_host.hangs == 0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		u_smsb_host.xfer(1'b0, a, 32'h0, q);
		tmo(u_smsb_host.hangs == 0);
		chk(q, e);
	endtask : rd

	task automatic run(input smsb_row_t r, input logic msk);
		int n;
		wr(`SMSB_OFF_CFG, {28'h0, r.cfg});
		wr(`SMSB_OFF_PWR, 32'h0);
		u_smsb_host.issue(r.ft, r.sc, r.cl, r.ch, r.op);
		tmo(u_smsb_host.hangs == 0);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (dev_busy !== 1'b1 && n < 4);
		tmo(dev_busy === 1'b1);
		n = 0;
		while (dev_busy === 1'b1 && n < 40) begin
			chk(intrq, 1'b0);
			@(negedge pclk);
			n++;
		end
		tmo(dev_busy === 1'b0);
		n = 0;
		while (intrq !== msk && n < 4) begin
			@(negedge pclk);
			n++;
		end
		chk(intrq, msk);
		rd(`SMSB_OFF_STATUS, {24'h0, 2'b01, 5'h0, r.err});
		rd(`SMSB_OFF_ERROR, {29'h0, r.err, 2'b00});
		rd(`SMSB_OFF_CYL_LO, {24'h0, (r.bad ? `SMSB_BAD_LO : r.cl)});
		rd(`SMSB_OFF_CYL_HI, {24'h0, (r.bad ? `SMSB_BAD_HI : r.ch)});
		chk(standby_mode, r.stby);
		u_smsb_host.xfer(1'b0, `SMSB_OFF_PWR, 32'h0, q);
		chk(q[1:0], {r.tmr, r.stby});
		rd(`SMSB_OFF_IRQ_STAT, {30'h0, r.err, 1'b1});
		@(negedge pclk);
		chk(intrq, 1'b0);
	endtask : run

	initial begin
		#(5 * 40000);
		fail_count++;
		end_sim();
	end

	initial begin
		int n;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk({intrq, standby_mode, dev_busy}, 3'b000);
		rd(`SMSB_OFF_CFG, {28'h0, `SMSB_CFG_RST});
		rd(`SMSB_OFF_STATUS, 32'h40);
		rd(`SMSB_OFF_IRQ_MASK, 32'h0);
		rd(`SMSB_OFF_PWR, 32'h0);
		// unmapped place: error response, nothing stored
		rd(8'h40, 32'h0);
		chk(u_smsb_host.err, 1'b1);
		wr(8'h44, 32'hffffffff);
		chk(u_smsb_host.err, 1'b1);
		wr(`SMSB_OFF_IRQ_MASK, 32'h7);
		rd(`SMSB_OFF_IRQ_MASK, 32'h7);
		chk(u_smsb_host.err, 1'b0);
		foreach (rows[i])
			run(rows[i], 1'b1);
		// threshold above the initial value trips, a higher value clears it
		wr(`SMSB_OFF_THR, 32'h7000);
		run(xrow, 1'b1);
		wr(`SMSB_OFF_ATTR, 32'h8000);
		run(rows[1], 1'b1);
		wr(`SMSB_OFF_IRQ_MASK, 32'h0);
		run(rows[2], 1'b0);
		wr(`SMSB_OFF_IRQ_MASK, 32'h7);
		// short period, then wake and let the timer put the device back to standby
		rows[7].sc = 8'h20;
		run(rows[7], 1'b1);
		rd(`SMSB_OFF_PWR, 32'h2003);
		wr(`SMSB_OFF_PWR, 32'h0);
		@(negedge pclk);
		chk(standby_mode, 1'b0);
		n = 0;
		while (standby_mode !== 1'b1 && n < 300) begin
			@(negedge pclk);
			n++;
		end
		tmo(standby_mode === 1'b1);
		rd(`SMSB_OFF_IRQ_STAT, 32'h4);
		// reset in mid-run: standby, timer and config must fall back
		presetn <= 1'b0;
		@(posedge pclk);
		chk({intrq, standby_mode, dev_busy}, 3'b000);
		presetn <= 1'b1;
		rd(`SMSB_OFF_PWR, 32'h0);
		rd(`SMSB_OFF_CFG, {28'h0, `SMSB_CFG_RST});
		end_sim();
	end
endmodule : smart_status_standby_cmd_tb
`default_nettype wire
